// file: common/osf_params.svh
// constants of the operand address and status flag slice
// assumes: included by bare name, by the address generator, the core and the bench
`ifndef OSF_PARAMS_SVH
`define OSF_PARAMS_SVH

// register byte offsets on the bus
`define OSF_STATUS_OFS  8'h00
`define OSF_CTRL_OFS    8'h04
`define OSF_EXT_OFS     8'h08
`define OSF_WREG_OFS    8'h0C
`define OSF_SRC_OFS     8'h10
`define OSF_DST_OFS     8'h14
`define OSF_PC_OFS      8'h18
`define OSF_DISP_OFS    8'h1C
`define OSF_WR12_OFS    8'h20
`define OSF_EA_OFS      8'h24
`define OSF_OPND_OFS    8'h28
`define OSF_RES_OFS     8'h2C
`define OSF_BIT_OFS     8'h30
`define OSF_INFO_OFS    8'h34

// status word, vector bit = 15 - documented bit
`define OSF_LGT_BIT     15
`define OSF_AGT_BIT     14
`define OSF_EQ_BIT      13
`define OSF_CY_BIT      12
`define OSF_OV_BIT      11
`define OSF_PAR_BIT     10
`define OSF_XOP_BIT     9
`define OSF_MASK_LSB    0
`define OSF_STATUS_RST  16'h0000
`define OSF_STATUS_WMSK 16'hFE0F

// control word fields, and the count field of the displacement
`define OSF_C_REG_LSB   0
`define OSF_C_MODE_LSB  4
`define OSF_C_BYTE_BIT  6
`define OSF_C_IMM_BIT   7
`define OSF_C_TWO_BIT   8
`define OSF_C_OP_LSB    9
`define OSF_C_PIN_BIT   14
`define OSF_D_CNT_LSB   8

// arithmetic constants
`define OSF_STEP_BYTE   16'h0001
`define OSF_STEP_WORD   16'h0002
`define OSF_NEG_LIMIT   16'h8000
`define OSF_PORT_CNT_MX 4'h8

`endif

// file: common/osf_pkg.sv
// types of the operand address and status flag slice
// assumes: the params header sits on the include path
package osf_pkg;
	typedef enum logic [4:0] {
		OSF_OP_NONE = 5'h00, OSF_OP_CMP = 5'h01, OSF_OP_ADD = 5'h02,
		OSF_OP_SUB  = 5'h03, OSF_OP_INC = 5'h04, OSF_OP_DEC = 5'h05,
		OSF_OP_NEG  = 5'h06, OSF_OP_ABS = 5'h07, OSF_OP_MOV = 5'h08,
		OSF_OP_SOC  = 5'h09, OSF_OP_SZC = 5'h0A, OSF_OP_XOR = 5'h0B,
		OSF_OP_SRA  = 5'h0C, OSF_OP_SRL = 5'h0D, OSF_OP_SRC = 5'h0E,
		OSF_OP_SLA  = 5'h0F, OSF_OP_COC = 5'h10, OSF_OP_CZC = 5'h11,
		OSF_OP_TB   = 5'h12, OSF_OP_XOP = 5'h13, OSF_OP_PORT = 5'h14,
		OSF_OP_LOAD_MASK_IMMEDIATE = 5'h15, OSF_OP_CONTEXT_RETURN = 5'h16, OSF_OP_JMP = 5'h17
	} osf_op_e;
	typedef enum logic [1:0] {
		OSF_M_REG = 2'h0, OSF_M_IND = 2'h1,
		OSF_M_IDX = 2'h2, OSF_M_AUTO = 2'h3
	} osf_mode_e;
	typedef enum logic [2:0] {
		OSF_S_IDLE = 3'h1, OSF_S_ADDR = 3'h2, OSF_S_INCR = 3'h4
	} osf_fsm_e;
	typedef struct packed {
		osf_fsm_e     fsm;
		logic         ack;
		logic [31:0]  rdat;
		logic [15:0]  status;
		logic [15:0]  ctrl;
		logic [15:0]  ext;
		logic [15:0]  wreg;
		logic [15:0]  src;
		logic [15:0]  dst;
		logic [15:0]  pc;
		logic [11:0]  disp;
		logic [15:0]  wr12;
		logic [15:0]  ea;
		logic [15:0]  opnd;
		logic [15:0]  res;
		logic [11:0]  bitad;
	} osf_regs_s;
endpackage : osf_pkg

// file: src/osf_addr_gen.sv
// effective address, operand, jump target and bit port address forming
// assumes: purely combinational, inputs held stable by the caller
`timescale 1ns/1ns
`include "osf_params.svh"
module osf_addr_gen
	import osf_pkg::*;
(
	input  wire logic [1:0]  mode,
	input  wire logic [3:0]  regnum,
	input  wire logic        byte_op,
	input  wire logic        imm,
	input  wire logic [15:0] wreg,
	input  wire logic [15:0] ext,
	input  wire logic [15:0] pc,
	input  wire logic [7:0]  disp,
	input  wire logic [15:0] wr12,
	output logic      [15:0] ea,
	output logic      [15:0] opnd,
	output logic      [15:0] wreg_inc,
	output logic      [15:0] pc_jump,
	output logic      [11:0] bit_addr
);
	logic direct;
	logic indexed;
	assign direct  = (mode == OSF_M_IDX) && (regnum == 4'h0);
	assign indexed = (mode == OSF_M_IDX) && (regnum != 4'h0);
	always_comb begin
		ea = 16'h0000;
		if (!imm) begin
			if (mode == OSF_M_IND || mode == OSF_M_AUTO)
				ea = wreg;
			else if (direct)
				ea = ext;
			else if (indexed)
				ea = ext + wreg;
		end
	end
	// byte operand in a register is its left byte
	always_comb begin
		opnd = 16'h0000;
		if (imm)
			opnd = ext;
		else if (mode == OSF_M_REG)
			opnd = byte_op ? {wreg[15:8], 8'h00} : wreg;
	end
	assign wreg_inc = wreg + (byte_op ? `OSF_STEP_BYTE : `OSF_STEP_WORD);
	assign pc_jump  = pc + {{7{disp[7]}}, disp, 1'b0};
	assign bit_addr = wr12[12:1] + {{4{disp[7]}}, disp};
endmodule : osf_addr_gen

// file: src/osf_shifter.sv
// four-kind word shifter, count 0 meaning sixteen
// assumes: purely combinational
`timescale 1ns/1ns
module osf_shifter (
	input  wire logic [1:0]  kind,
	input  wire logic [15:0] val,
	input  wire logic [3:0]  cnt,
	output logic      [15:0] res,
	output logic             last_out,
	output logic             msb_chg
);
	// kind: 0 arithmetic right, 1 logical right, 2 circular, 3 arith left
	logic [15:0] stg [0:16];
	logic        co  [0:16];
	logic        chg [0:16];
	logic [4:0]  n;
	assign n      = (cnt == 4'h0) ? 5'h10 : {1'b0, cnt};
	assign stg[0] = val;
	assign co[0]  = 1'b0;
	assign chg[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_step
			logic        en;
			logic [15:0] nx;
			assign en = (5'(i) < n);
			always_comb begin
				case (kind)
					2'h0: nx = {stg[i][15], stg[i][15:1]};
					2'h1: nx = {1'b0, stg[i][15:1]};
					2'h2: nx = {stg[i][0], stg[i][15:1]};
					default: nx = {stg[i][14:0], 1'b0};
				endcase
			end
			assign stg[i+1] = en ? nx : stg[i];
			assign co[i+1]  = en ? ((kind == 2'h3) ? stg[i][15] : stg[i][0])
				: co[i];
			assign chg[i+1] = chg[i] | (en & (nx[15] ^ stg[i][15]));
		end
	endgenerate
	assign res      = stg[16];
	assign last_out = co[16];
	assign msb_chg  = chg[16];
endmodule : osf_shifter

// file: src/osf_core.sv
// operand address and status flag slice with a classic wishbone slave
// assumes: single clock, master keeps a request until it sees ack
`timescale 1ns/1ns
`include "osf_params.svh"
module osf_core
	import osf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [15:0] status_word,
	output logic             busy
);
	localparam osf_regs_s ST_RST = '{
		fsm: OSF_S_IDLE, status: `OSF_STATUS_RST, default: '0
	};

	osf_regs_s st;
	osf_regs_s next_st;

	function automatic logic [15:0] osf_wmerge(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel
	);
		osf_wmerge = {sel[1] ? dat[15:8] : old[15:8],
			sel[0] ? dat[7:0] : old[7:0]};
	endfunction : osf_wmerge

	// decoded control
	osf_op_e     op;
	logic [1:0]  mode;
	logic [3:0]  regnum;
	logic        byte_op;
	logic        imm;
	logic        by_two;
	logic        port_in;
	logic        autoinc;
	logic [3:0]  cnt;
	assign op      = osf_op_e'(st.ctrl[`OSF_C_OP_LSB +: 5]);
	assign mode    = st.ctrl[`OSF_C_MODE_LSB +: 2];
	assign regnum  = st.ctrl[`OSF_C_REG_LSB +: 4];
	assign byte_op = st.ctrl[`OSF_C_BYTE_BIT];
	assign imm     = st.ctrl[`OSF_C_IMM_BIT];
	assign by_two  = st.ctrl[`OSF_C_TWO_BIT];
	assign port_in = st.ctrl[`OSF_C_PIN_BIT];
	assign cnt     = st.disp[`OSF_D_CNT_LSB +: 4];
	assign autoinc = (mode == OSF_M_AUTO) && !imm;

	logic [15:0] ea;
	logic [15:0] opnd;
	logic [15:0] wreg_inc;
	logic [15:0] pc_jump;
	logic [11:0] bit_addr;
	osf_addr_gen u_addr (
		.mode     (mode),
		.regnum   (regnum),
		.byte_op  (byte_op),
		.imm      (imm),
		.wreg     (st.wreg),
		.ext      (st.ext),
		.pc       (st.pc),
		.disp     (st.disp[7:0]),
		.wr12     (st.wr12),
		.ea       (ea),
		.opnd     (opnd),
		.wreg_inc (wreg_inc),
		.pc_jump  (pc_jump),
		.bit_addr (bit_addr)
	);

	logic [15:0] sh_res;
	logic        sh_last;
	logic        sh_chg;
	osf_shifter u_shift (
		.kind     (2'(op - OSF_OP_SRA)),
		.val      (st.src),
		.cnt      (cnt),
		.res      (sh_res),
		.last_out (sh_last),
		.msb_chg  (sh_chg)
	);

	// byte operands live in the left byte, right byte zero
	logic [15:0] s;
	logic [15:0] d;
	logic [15:0] k;
	logic [16:0] sum;
	logic [16:0] dif;
	logic [16:0] inc;
	logic [16:0] dec;
	logic [16:0] neg;
	assign s   = byte_op ? {st.src[15:8], 8'h00} : st.src;
	assign d   = byte_op ? {st.dst[15:8], 8'h00} : st.dst;
	assign k   = by_two ? `OSF_STEP_WORD : `OSF_STEP_BYTE;
	assign sum = {1'b0, s} + {1'b0, d};
	assign dif = {1'b0, d} + {1'b0, ~s} + 17'h00001;
	assign inc = {1'b0, s} + {1'b0, k};
	assign dec = {1'b0, s} + {1'b0, ~k} + 17'h00001;
	assign neg = {1'b0, ~s} + 17'h00001;

	// flag generation
	logic [15:0] r;
	logic [15:0] fl;
	logic [15:0] upd;
	logic        s15;
	logic        d15;
	assign s15 = s[15];
	assign d15 = d[15];
	always_comb begin
		r   = s;
		fl  = 16'h0000;
		upd = 16'h0000;
		case (op)
			OSF_OP_ADD: r = sum[15:0];
			OSF_OP_SUB, OSF_OP_CMP: r = dif[15:0];
			OSF_OP_INC: r = inc[15:0];
			OSF_OP_DEC: r = dec[15:0];
			OSF_OP_NEG: r = neg[15:0];
			OSF_OP_ABS: r = s15 ? neg[15:0] : s;
			OSF_OP_SOC: r = d | s;
			OSF_OP_SZC: r = d & ~s;
			OSF_OP_XOR: r = d ^ s;
			OSF_OP_SRA, OSF_OP_SRL, OSF_OP_SRC, OSF_OP_SLA: r = sh_res;
			default: r = s;
		endcase
		// general result tests, overridden below where needed
		fl[`OSF_LGT_BIT] = (r != 16'h0000);
		fl[`OSF_AGT_BIT] = !r[15] && (r != 16'h0000);
		fl[`OSF_EQ_BIT]  = (r == 16'h0000);
		fl[`OSF_PAR_BIT] = ^r[15:8];
		case (op)
			OSF_OP_CMP: begin
				fl[`OSF_LGT_BIT] = (s15 && !d15)
					|| (s15 == d15 && r[15]);
				fl[`OSF_AGT_BIT] = (!s15 && d15)
					|| (s15 == d15 && r[15]);
				fl[`OSF_EQ_BIT]  = (s == d);
				fl[`OSF_PAR_BIT] = ^s[15:8];
				upd = 16'hE000 | (byte_op ? 16'h0400 : 16'h0000);
			end
			OSF_OP_ADD, OSF_OP_SUB: begin
				fl[`OSF_CY_BIT] = (op == OSF_OP_ADD) ? sum[16]
					: dif[16];
				fl[`OSF_OV_BIT] = (op == OSF_OP_ADD)
					? (s15 == d15 && r[15] != d15)
					: (s15 != d15 && r[15] != d15);
				upd = 16'hF800 | (byte_op ? 16'h0400 : 16'h0000);
			end
			OSF_OP_INC, OSF_OP_DEC: begin
				fl[`OSF_CY_BIT] = (op == OSF_OP_INC) ? inc[16]
					: dec[16];
				fl[`OSF_OV_BIT] = (op == OSF_OP_INC) ? (!s15 && r[15])
					: (s15 && !r[15]);
				upd = 16'hF800;
			end
			OSF_OP_NEG, OSF_OP_ABS: begin
				if (op == OSF_OP_ABS) begin
					// absolute value tests the source, not the result
					fl[`OSF_LGT_BIT] = (s != 16'h0000);
					fl[`OSF_AGT_BIT] = !s15 && (s != 16'h0000);
					fl[`OSF_EQ_BIT]  = (s == 16'h0000);
				end
				fl[`OSF_CY_BIT] = (op == OSF_OP_NEG || s15)
					&& neg[16];
				fl[`OSF_OV_BIT] = (s == `OSF_NEG_LIMIT);
				upd = 16'hF800;
			end
			OSF_OP_MOV, OSF_OP_SOC, OSF_OP_SZC, OSF_OP_XOR:
				upd = 16'hE000 | (byte_op ? 16'h0400 : 16'h0000);
			OSF_OP_SRA, OSF_OP_SRL, OSF_OP_SRC, OSF_OP_SLA: begin
				fl[`OSF_CY_BIT] = sh_last;
				fl[`OSF_OV_BIT] = sh_chg;
				upd = (op == OSF_OP_SLA) ? 16'hF800 : 16'hF000;
			end
			OSF_OP_COC, OSF_OP_CZC, OSF_OP_TB: begin
				fl[`OSF_EQ_BIT] = (op == OSF_OP_TB) ? port_in
					: (op == OSF_OP_COC) ? ((s & ~d) == 16'h0000)
					: ((s & d) == 16'h0000);
				upd = 16'h2000;
			end
			OSF_OP_XOP: begin
				fl[`OSF_XOP_BIT] = 1'b1;
				upd = 16'h0200;
			end
			OSF_OP_PORT: begin
				fl[`OSF_PAR_BIT] = ^s[15:8];
				// counts above eight and zero leave parity alone
				upd = (cnt != 4'h0 && cnt <= `OSF_PORT_CNT_MX)
					? 16'h0400 : 16'h0000;
			end
			OSF_OP_LOAD_MASK_IMMEDIATE: begin
				fl[`OSF_MASK_LSB +: 4] = st.src[3:0];
				upd = 16'h000F;
			end
			OSF_OP_CONTEXT_RETURN: begin
				fl  = st.src;
				upd = `OSF_STATUS_WMSK;
			end
			default: upd = 16'h0000;
		endcase
	end

	// bus decode
	logic req;
	logic wr_acc;
	logic idle;
	assign req    = wb_cyc_i && wb_stb_i;
	assign idle   = (st.fsm == OSF_S_IDLE);
	// writes land at the edge where ack is seen; busy writes are dropped
	assign wr_acc = req && wb_we_i && st.ack && idle;

	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case ({wb_adr_i[7:2], 2'b00})
			`OSF_STATUS_OFS: rd[15:0] = st.status;
			`OSF_CTRL_OFS:   rd[15:0] = st.ctrl;
			`OSF_EXT_OFS:    rd[15:0] = st.ext;
			`OSF_WREG_OFS:   rd[15:0] = st.wreg;
			`OSF_SRC_OFS:    rd[15:0] = st.src;
			`OSF_DST_OFS:    rd[15:0] = st.dst;
			`OSF_PC_OFS:     rd[15:0] = st.pc;
			`OSF_DISP_OFS:   rd[11:0] = st.disp;
			`OSF_WR12_OFS:   rd[15:0] = st.wr12;
			`OSF_EA_OFS:     rd[15:0] = st.ea;
			`OSF_OPND_OFS:   rd[15:0] = st.opnd;
			`OSF_RES_OFS:    rd[15:0] = st.res;
			`OSF_BIT_OFS:    rd[11:0] = st.bitad;
			`OSF_INFO_OFS:   rd[0]    = !idle;
			default:         rd       = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_st     = st;
		next_st.ack = req && !st.ack;
		if (req && !st.ack)
			next_st.rdat = rd;
		if (wr_acc) begin
			case ({wb_adr_i[7:2], 2'b00})
				`OSF_STATUS_OFS: next_st.status =
					osf_wmerge(st.status, wb_dat_i, wb_sel_i)
					& `OSF_STATUS_WMSK;
				`OSF_CTRL_OFS: begin
					next_st.ctrl = osf_wmerge(st.ctrl, wb_dat_i, wb_sel_i);
					next_st.fsm  = OSF_S_ADDR;
				end
				`OSF_EXT_OFS: next_st.ext =
					osf_wmerge(st.ext, wb_dat_i, wb_sel_i);
				`OSF_WREG_OFS: next_st.wreg =
					osf_wmerge(st.wreg, wb_dat_i, wb_sel_i);
				`OSF_SRC_OFS: next_st.src =
					osf_wmerge(st.src, wb_dat_i, wb_sel_i);
				`OSF_DST_OFS: next_st.dst =
					osf_wmerge(st.dst, wb_dat_i, wb_sel_i);
				`OSF_PC_OFS: next_st.pc =
					osf_wmerge(st.pc, wb_dat_i, wb_sel_i);
				`OSF_DISP_OFS: next_st.disp =
					12'(osf_wmerge({4'h0, st.disp}, wb_dat_i, wb_sel_i));
				`OSF_WR12_OFS: next_st.wr12 =
					osf_wmerge(st.wr12, wb_dat_i, wb_sel_i);
				default: next_st.fsm = st.fsm;
			endcase
		end
		case (st.fsm)
			OSF_S_IDLE: begin
			end
			OSF_S_ADDR: begin
				next_st.ea    = ea;
				next_st.opnd  = opnd;
				next_st.bitad = bit_addr;
				// right byte of a byte destination stays as it was
				next_st.res   = byte_op ? {r[15:8], st.dst[7:0]}
					: r;
				next_st.status = ((st.status & ~upd) | (fl & upd))
					& `OSF_STATUS_WMSK;
				if (op == OSF_OP_JMP)
					next_st.pc = pc_jump;
				next_st.fsm = autoinc ? OSF_S_INCR : OSF_S_IDLE;
			end
			OSF_S_INCR: begin
				next_st.wreg = wreg_inc;
				next_st.fsm  = OSF_S_IDLE;
			end
			default: next_st.fsm = OSF_S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign wb_dat_o    = st.rdat;
	assign wb_ack_o    = st.ack;
	assign status_word = st.status;
	assign busy        = !idle;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_status_zero: assert property (
		st.status[8:4] == 5'h00
	) else $error("unused status bits not zero");

	chk_reg_operand: assert property (
		st.fsm == OSF_S_ADDR && mode == OSF_M_REG && !imm && !byte_op
		|=> st.opnd == $past(st.wreg)
	) else $error("register operand wrong");

	chk_ind_addr: assert property (
		st.fsm == OSF_S_ADDR && mode == OSF_M_IND && !imm
		|=> st.ea == $past(st.wreg) && st.fsm == OSF_S_IDLE
	) else $error("indirect address wrong");

	chk_autoinc_order: assert property (
		st.fsm == OSF_S_ADDR && autoinc
		|=> st.ea == $past(st.wreg) && st.wreg == $past(st.wreg)
		##1 st.wreg != $past(st.wreg) && st.fsm == OSF_S_IDLE
	) else $error("auto increment order wrong");

	chk_autoinc_step: assert property (
		st.fsm == OSF_S_INCR |=> st.wreg == $past(st.wreg)
		+ ($past(byte_op) ? `OSF_STEP_BYTE : `OSF_STEP_WORD)
	) else $error("auto increment step wrong");

	chk_direct_zero: assert property (
		st.fsm == OSF_S_ADDR && mode == OSF_M_IDX && regnum == 4'h0
		&& !imm |=> st.ea == $past(st.ext)
	) else $error("register zero indexed");

	chk_index_sum: assert property (
		st.fsm == OSF_S_ADDR && mode == OSF_M_IDX && regnum != 4'h0
		&& !imm |=> st.ea == 16'($past(st.ext) + $past(st.wreg))
	) else $error("indexed address wrong");

	chk_imm_operand: assert property (
		st.fsm == OSF_S_ADDR && imm |=> st.opnd == $past(st.ext)
	) else $error("immediate operand wrong");

	chk_jump_target: assert property (
		st.fsm == OSF_S_ADDR && op == OSF_OP_JMP
		|=> st.pc == 16'($past(st.pc)
		+ {{7{$past(st.disp[7])}}, $past(st.disp[7:0]), 1'b0})
	) else $error("jump target wrong");

	chk_xop_flag: assert property (
		st.fsm == OSF_S_ADDR && op == OSF_OP_XOP
		|=> st.status[`OSF_XOP_BIT] && $stable(st.status[15:10])
	) else $error("extended op flag not set");

	chk_mask_load: assert property (
		st.fsm == OSF_S_ADDR && op == OSF_OP_LOAD_MASK_IMMEDIATE
		|=> st.status[3:0] == $past(st.src[3:0])
		&& $stable(st.status[15:9])
	) else $error("interrupt mask load wrong");

	chk_test_keeps: assert property (
		st.fsm == OSF_S_ADDR && op == OSF_OP_TB
		|=> st.status[`OSF_EQ_BIT] == $past(port_in)
		&& $stable(st.status[12:0]) && $stable(st.status[15:14])
	) else $error("test bit changed other flags");

	chk_bus_ack: assert property (
		req && !st.ack |=> st.ack ##1 !st.ack
	) else $error("ack not one cycle after request");
endmodule : osf_core

// file: tb/osf_core_tb.sv
// self-checking bench for the operand address and status flag slice
// assumes: package and params header compiled, wishbone slave acks once
`timescale 1ns/1ns
`include "osf_params.svh"
module osf_core_tb
	import osf_pkg::*;
();
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h00000000, rdat;
	logic        ack, busy;
	logic [15:0] status_word;
	int          fail_count = 0, checked = 0, cycles = 0;
	logic [31:0] seed = 32'hEAD4C6F3;
	logic [15:0] st, s, d, w, e;
	logic [15:0] edges [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
	osf_op_e     ops [17] = '{OSF_OP_CMP, OSF_OP_ADD, OSF_OP_SUB, OSF_OP_INC,
		OSF_OP_DEC, OSF_OP_NEG, OSF_OP_MOV, OSF_OP_SOC, OSF_OP_SZC, OSF_OP_XOR,
		OSF_OP_COC, OSF_OP_CZC, OSF_OP_TB, OSF_OP_XOP, OSF_OP_LOAD_MASK_IMMEDIATE,
		OSF_OP_ABS, OSF_OP_CONTEXT_RETURN};

	always #50 clk = ~clk;

	osf_core i_dut (
		.clk        (clk),
		.nrst       (nrst),
		.wb_cyc_i   (cyc),
		.wb_stb_i   (stb),
		.wb_we_i    (we),
		.wb_adr_i   (adr),
		.wb_sel_i   (sel),
		.wb_dat_i   (wdat),
		.wb_dat_o   (rdat),
		.wb_ack_o   (ack),
		.status_word(status_word),
		.busy       (busy)
	);

	task results();
		$display("mismatches %0d of %0d checks", fail_count, checked);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			results();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs

	task rnd(output logic [15:0] v);
		seed = xs(seed);
		v = seed[15:0];
	endtask : rnd

	task chk_reg(input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: exp %h got %h", $time, exp, got);
		end
	endtask : chk_reg

	task chk_flag(input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected flag at %0t: exp %h got %h", $time, exp, got);
		end
	endtask : chk_flag

	// one classic cycle; ack and data taken at the edge that samples ack
	task wb(input logic wr, input logic [7:0] a, input logic [15:0] dv,
		output logic [15:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0000, dv};
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [15:0] dv);
		logic [15:0] q;
		wb(1'b1, a, dv, q);
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] q;
		wb(1'b0, a, 16'h0000, q);
		chk_reg(exp, q);
	endtask : rd_chk

	task run(input logic [15:0] c);
		wr(`OSF_CTRL_OFS, c);
		@(posedge clk);
		while (busy !== 1'b0) @(posedge clk);
	endtask : run

	// f = {port in, by two, immediate, byte}
	function automatic logic [15:0] mkc(input logic [4:0] op,
		input logic [3:0] f, input logic [1:0] m, input logic [3:0] rg);
		return {1'b0, f[3], op, f[2:0], m, rg};
	endfunction : mkc

	task acase(input logic [15:0] c, input logic [7:0] a,
		input logic [15:0] exp);
		wr(`OSF_WREG_OFS, w);
		wr(`OSF_EXT_OFS, e);
		run(c);
		rd_chk(a, exp);
	endtask : acase

	task automatic model(input logic [4:0] op, input logic two, pin,
		output logic [15:0] rr, output logic hasr);
		logic [16:0] x;
		logic        ar, gen;
		x = 17'h00000;
		ar = 1'b0;
		gen = 1'b1;
		hasr = 1'b1;
		rr = 16'h0000;
		case (op)
			OSF_OP_CMP: begin
				rr = d - s;
				gen = 1'b0;
				st[15] = (s[15] & ~d[15]) | (s[15] == d[15] & rr[15]);
				st[14] = (~s[15] & d[15]) | (s[15] == d[15] & rr[15]);
				st[13] = s == d;
			end
			OSF_OP_ADD: begin
				x = s + d;
				ar = 1'b1;
				st[11] = s[15] == d[15] && x[15] != d[15];
			end
			OSF_OP_SUB: begin
				x = {1'b0, d} + {1'b0, ~s} + 17'h00001;
				ar = 1'b1;
				st[11] = s[15] != d[15] && x[15] != d[15];
			end
			OSF_OP_INC: begin
				x = s + (two ? 17'h00002 : 17'h00001);
				ar = 1'b1;
				st[11] = ~s[15] & x[15];
			end
			OSF_OP_DEC: begin
				x = s + (two ? 17'h0FFFE : 17'h0FFFF);
				ar = 1'b1;
				st[11] = s[15] & ~x[15];
			end
			OSF_OP_NEG: begin
				x = {1'b0, ~s} + 17'h00001;
				ar = 1'b1;
				st[11] = s == `OSF_NEG_LIMIT;
			end
			OSF_OP_ABS: begin
				// flags test the source, carry only from negation
				x = s[15] ? {1'b0, ~s} + 17'h00001 : {1'b0, s};
				ar = 1'b1;
				gen = 1'b0;
				rr = x[15:0];
				st[15] = s != 16'h0000;
				st[14] = ~s[15] && s != 16'h0000;
				st[13] = s == 16'h0000;
				st[11] = s == `OSF_NEG_LIMIT;
			end
			OSF_OP_MOV: x = s;
			OSF_OP_SOC: x = s | d;
			OSF_OP_SZC: x = d & ~s;
			OSF_OP_XOR: x = d ^ s;
			default: begin
				gen = 1'b0;
				hasr = 1'b0;
				if (op == OSF_OP_COC) st[13] = (s & d) == s;
				if (op == OSF_OP_CZC) st[13] = (s & d) == 16'h0000;
				if (op == OSF_OP_TB) st[13] = pin;
				if (op == OSF_OP_XOP) st[9] = 1'b1;
				if (op == OSF_OP_LOAD_MASK_IMMEDIATE) st[3:0] = s[3:0];
				if (op == OSF_OP_CONTEXT_RETURN) st = s & `OSF_STATUS_WMSK;
			end
		endcase
		if (gen) begin
			rr = x[15:0];
			st[15] = rr != 16'h0000;
			st[14] = ~rr[15] && rr != 16'h0000;
			st[13] = rr == 16'h0000;
		end
		if (ar) st[12] = x[16];
	endtask : model

	initial begin
		logic [15:0] c, q, r;
		logic        hasr;
		int          k, i;
		repeat (10) @(posedge clk);
		chk_reg(`OSF_STATUS_RST, status_word);
		nrst <= 1'b1;
		rd_chk(8'h3C, 16'h0000);
		rnd(w);
		rnd(e);
		acase(mkc(OSF_OP_NONE,4'h0,OSF_M_REG,4'h3),`OSF_OPND_OFS,w);
		acase(mkc(OSF_OP_NONE,4'h0,OSF_M_IND,4'h3),`OSF_EA_OFS,w);
		acase(mkc(OSF_OP_NONE,4'h0,OSF_M_IDX,4'h0),`OSF_EA_OFS,e);
		acase(mkc(OSF_OP_NONE,4'h0,OSF_M_IDX,4'h5),`OSF_EA_OFS,e+w);
		acase(mkc(OSF_OP_NONE,4'h2,OSF_M_REG,4'h1),`OSF_OPND_OFS,e);
		acase(mkc(OSF_OP_NONE,4'h0,OSF_M_AUTO,4'h7),`OSF_EA_OFS,w);
		rd_chk(`OSF_WREG_OFS, w + `OSF_STEP_WORD);
		acase(mkc(OSF_OP_NONE,4'h1,OSF_M_AUTO,4'h7),`OSF_EA_OFS,w);
		rd_chk(`OSF_WREG_OFS, w + `OSF_STEP_BYTE);
		for (k = 0; k < 4; k++) begin
			rnd(w);
			rnd(e);
			if (k < 2) e[7:0] = k ? 8'h80 : 8'h7F;
			wr(`OSF_PC_OFS, w);
			wr(`OSF_DISP_OFS, {8'h00, e[7:0]});
			run(mkc(OSF_OP_JMP, 4'h0, OSF_M_REG, 4'h0));
			rd_chk(`OSF_PC_OFS, w + {{7{e[7]}}, e[7:0], 1'b0});
			wr(`OSF_WR12_OFS, w);
			run(mkc(OSF_OP_TB, 4'h0, OSF_M_REG, 4'h0));
			rd_chk(`OSF_BIT_OFS, {4'h0, w[12:1] + {{4{e[7]}}, e[7:0]}});
		end
		// every count from 0 to 15; odd upper byte of the source
		for (k = 0; k < 16; k++) begin
			wr(`OSF_STATUS_OFS, 16'h0000);
			wr(`OSF_SRC_OFS, 16'h0700);
			wr(`OSF_DISP_OFS, {4'h0, k[3:0], 8'h00});
			run(mkc(OSF_OP_PORT, 4'h0, OSF_M_REG, 4'h0));
			wb(1'b0, `OSF_STATUS_OFS, 16'h0000, q);
			chk_flag(k >= 1 && k <= 8, q[`OSF_PAR_BIT]);
		end
		rnd(r);
		wr(`OSF_STATUS_OFS, r);
		st = r & `OSF_STATUS_WMSK;
		rd_chk(`OSF_STATUS_OFS, st);
		for (k = 0; k < 160; k++) begin
			rnd(s);
			rnd(d);
			rnd(c);
			if (c[15]) s = edges[c[14:13]];
			if (c[12]) d = s;
			i = c[4:0] % 17;
			wr(`OSF_SRC_OFS, s);
			wr(`OSF_DST_OFS, d);
			run(mkc(ops[i], {c[10], c[11], 2'b00}, OSF_M_REG, 4'h2));
			model(ops[i], c[11], c[10], r, hasr);
			wb(1'b0, `OSF_STATUS_OFS, 16'h0000, q);
			chk_reg(st&16'hF000, q&16'hF000);
			chk_reg(st&16'h0800, q&16'h0800);
			chk_reg(st&16'h07FF, q&16'h07FF);
			if (hasr) rd_chk(`OSF_RES_OFS, r);
		end
		results();
	end
endmodule : osf_core_tb
